// >>> common/cpw_regs.svh
// Purpose: Constants for the complementary PWM channel
// Assumes: Included by bare name after the package
// Notes:   Definitions only
`ifndef CPW_REGS_SVH
`define CPW_REGS_SVH

// Counter width and the half width of the crest/trough window in counts
`define CPW_CNT_WIDTH      16
`define CPW_WIN_COUNTS     2
// Reset values of the duty chain and of the outputs
`define CPW_DUTY_RESET     16'h0000
`define CPW_POS_RESET      1'b0
`define CPW_NEG_RESET      1'b0
// Mode select encoding
`define CPW_MODE_TWO       1'b0
`define CPW_MODE_THREE     1'b1

`endif

// >>> common/cpw_pkg.sv
// Purpose: Types for the complementary PWM channel
// Assumes: Nothing
// Notes:   One-hot counter direction states
`default_nettype none

package cpw_pkg;

    typedef enum logic [2:0] {
        CPW_IDLE = 3'b001,
        CPW_UP   = 3'b010,
        CPW_DOWN = 3'b100
    } cpw_state_t;

    typedef enum logic {
        CPW_M2 = 1'b0,
        CPW_M3 = 1'b1
    } cpw_mode_t;

endpackage : cpw_pkg

`default_nettype wire

// >>> logic/cpw_duty_chain.sv
// Purpose: Duty buffer, temporary and active compare registers
// Assumes: One transfer tick per transfer point
// Notes:   Both stages move on the same edge so the pair stays coherent
`default_nettype none
`include "cpw_regs.svh"

module cpw_duty_chain
    import cpw_pkg::*;
#(
    parameter int W = `CPW_CNT_WIDTH
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         dutyWrite,
    input  wire logic [W-1:0] dutyWriteData,
    input  wire logic         transferTick,
    output logic      [W-1:0] dutyBufferValue,
    output logic      [W-1:0] dutyTemporaryValue,
    output logic      [W-1:0] dutyCompareValue
);

    logic [W-1:0] duty_buffer_reg;
    logic [W-1:0] duty_temporary_reg;
    logic [W-1:0] duty_compare_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_buffer_reg    <= W'(`CPW_DUTY_RESET);
            duty_temporary_reg <= W'(`CPW_DUTY_RESET);
            duty_compare_reg   <= W'(`CPW_DUTY_RESET);
        end else begin
            if (dutyWrite) begin
                duty_buffer_reg <= dutyWriteData;
            end
            if (transferTick) begin
                duty_temporary_reg <= duty_buffer_reg;
                duty_compare_reg   <= duty_temporary_reg;
            end
        end
    end

    assign dutyBufferValue    = duty_buffer_reg;
    assign dutyTemporaryValue = duty_temporary_reg;
    assign dutyCompareValue   = duty_compare_reg;

endmodule // cpw_duty_chain

`default_nettype wire

// >>> logic/cpw_channel.sv
// Purpose: One complementary PWM channel with near-zero duty handling
// Assumes: Period above twice the window width; software writes duty
// Notes:   Counter runs trough to crest and back, outputs start at trough
//
// Operation
// - Compare register match turns positive phase on
// - Temporary register match turns positive phase off
// - Already-off positive phase stays off cleanly
// - Earlier off in half-cycle blocks on
// - Simultaneous negative on and off: no change
// - Compare match turns negative phase off
// - Temporary match turns negative phase on
// - Same switching for either write window
// - Mode two accepts writes around the crest
// - Modes two and three, start at trough
`default_nettype none
`include "cpw_regs.svh"

module cpw_channel
    import cpw_pkg::*;
#(
    parameter int W       = `CPW_CNT_WIDTH,
    parameter int WIN_CNT = `CPW_WIN_COUNTS
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         runEnable,
    input  wire logic         modeSelect,
    input  wire logic [W-1:0] carrierPeriodCompare,
    input  wire logic         dutyWrite,
    input  wire logic [W-1:0] dutyWriteData,
    output logic              positivePhase,
    output logic              negativePhase,
    output logic      [W-1:0] counterValue,
    output logic              counterUp,
    output logic              inCountingWindow,
    output logic              inCrestTroughWindow
);

    localparam logic [W-1:0] WinCount = W'(WIN_CNT);
    localparam logic [W-1:0] OneCount = W'(1);

    cpw_state_t   state_reg;
    cpw_state_t   state_next;
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         outActive_reg;
    logic         offSeen_reg;
    logic         offSeen_next;
    logic         positive_reg;
    logic         positive_next;
    logic         negative_reg;
    logic         negative_next;

    wire logic [W-1:0] dutyBufferValue;
    wire logic [W-1:0] dutyTemporaryValue;
    wire logic [W-1:0] dutyCompareValue;

    // Counter position decode
    wire logic atCrest     = (count_reg == carrierPeriodCompare);
    wire logic atTrough    = (count_reg == '0);
    wire logic isUp        = (state_reg == CPW_UP);
    wire logic isDown      = (state_reg == CPW_DOWN);
    wire logic running     = isUp | isDown;
    wire logic crestWin    = running &
                             (count_reg >= (carrierPeriodCompare - WinCount));
    wire logic troughWin   = running & (count_reg <= WinCount);
    wire logic crestLeave  = isDown &
                             (count_reg == (carrierPeriodCompare - WinCount));
    wire logic troughLeave = isUp & (count_reg == WinCount);
    wire logic turnAround  = (isUp & atCrest) | (isDown & atTrough);
    wire logic startAtBase = (state_reg == CPW_IDLE) & runEnable;
    wire logic modeThree   = (modeSelect == `CPW_MODE_THREE);

    // mode two takes up on leaving the crest window
    // mode three also takes up on leaving the trough window
    // Taking up at the window exit means a write anywhere before it counts
    wire logic transferTick = crestLeave | (modeThree & troughLeave);

    // Compare matches, qualified by active output
    // Run level gates at once, so the stop edge never switches a phase on
    wire logic outLive  = outActive_reg & runEnable;
    wire logic cmpMatch = outLive & (count_reg == dutyCompareValue);
    wire logic tmpMatch = outLive & (count_reg == dutyTemporaryValue);

    // zero duty is a buffer value equal to the period, so the match
    // lands on the crest; no special case is needed here

    // write timing never reaches the switching decode
    cpw_duty_chain #(
        .W (W)
    ) u_duty_chain (
        .clk                (clk),
        .rst_n              (rst_n),
        .dutyWrite          (dutyWrite),
        .dutyWriteData      (dutyWriteData),
        .transferTick       (transferTick),
        .dutyBufferValue    (dutyBufferValue),
        .dutyTemporaryValue (dutyTemporaryValue),
        .dutyCompareValue   (dutyCompareValue)
    );

    // Counter direction machine
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            CPW_IDLE: begin
                count_next = '0;
                if (runEnable) begin
                    state_next = CPW_UP;
                end
            end
            CPW_UP: begin
                if (!runEnable) begin
                    state_next = CPW_IDLE;
                    count_next = '0;
                end else if (atCrest) begin
                    state_next = CPW_DOWN;
                    count_next = count_reg - OneCount;
                end else begin
                    count_next = count_reg + OneCount;
                end
            end
            CPW_DOWN: begin
                if (!runEnable) begin
                    state_next = CPW_IDLE;
                    count_next = '0;
                end else if (atTrough) begin
                    state_next = CPW_UP;
                    count_next = count_reg + OneCount;
                end else begin
                    count_next = count_reg - OneCount;
                end
            end
            default: begin
                state_next = CPW_IDLE;
                count_next = '0;
            end
        endcase
    end

    // off seen in this half-cycle, cleared at the turn
    always_comb begin
        offSeen_next = offSeen_reg;
        if (turnAround | !running) begin
            offSeen_next = 1'b0;
        end
        if (tmpMatch) begin
            offSeen_next = 1'b1;
        end
    end

    // Positive phase: off wins over on, earlier off blocks later on
    always_comb begin
        positive_next = positive_reg;
        if (!outLive) begin
            positive_next = `CPW_POS_RESET;
        end else if (tmpMatch) begin
            positive_next = 1'b0;
        end else if (cmpMatch && !offSeen_reg) begin
            positive_next = 1'b1;
        end
    end

    // Negative phase: compare match off, temporary match on
    always_comb begin
        negative_next = negative_reg;
        if (!outLive) begin
            negative_next = `CPW_NEG_RESET;
        end else if (cmpMatch && tmpMatch) begin
            negative_next = negative_reg;
        end else if (cmpMatch) begin
            negative_next = 1'b0;
        end else if (tmpMatch) begin
            negative_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CPW_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // outputs come alive at the trough where counting starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outActive_reg <= 1'b0;
        end else if (!runEnable) begin
            outActive_reg <= 1'b0;
        end else if (startAtBase) begin
            outActive_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offSeen_reg  <= 1'b0;
            positive_reg <= `CPW_POS_RESET;
            negative_reg <= `CPW_NEG_RESET;
        end else begin
            offSeen_reg  <= offSeen_next;
            positive_reg <= positive_next;
            negative_reg <= negative_next;
        end
    end

    // Phase outputs straight from flip-flops to keep gate drive glitch free
    assign positivePhase       = positive_reg;
    assign negativePhase       = negative_reg;
    assign counterValue        = count_reg;
    assign counterUp           = isUp;
    assign inCrestTroughWindow = crestWin | troughWin;
    assign inCountingWindow    = running & !(crestWin | troughWin);

endmodule // cpw_channel

`default_nettype wire

// >>> tb/cpw_channel_monitor.sv
// Purpose: Port checker for the PWM channel
// Assumes: Duty chain shadowed from write and count ports
// Notes:   Off flag set on a turn carries into the next half cycle
`default_nettype none
module cpw_channel_monitor
    import cpw_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic         runEnable,
    input wire logic         modeSelect,
    input wire logic [W-1:0] carrierPeriodCompare,
    input wire logic         dutyWrite,
    input wire logic [W-1:0] dutyWriteData,
    input wire logic         positivePhase,
    input wire logic         negativePhase,
    input wire logic [W-1:0] counterValue,
    input wire logic         counterUp
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [W-1:0] buf_reg, tmp_reg, cmp_reg;
    logic         run_reg, off_reg;
    wire live = run_reg && runEnable;
    wire atTop = counterValue == carrierPeriodCompare;
    wire turnHit = live && (counterUp ? atTop : counterValue == '0);
    wire upTick = modeSelect && counterValue == 16'h0002;
    wire dnTick = counterValue == carrierPeriodCompare - 16'h0002;
    // Transfers follow the counter state, not the run level
    wire tick = run_reg && (counterUp ? upTick : dnTick);
    wire cmpHit = live && counterValue == cmp_reg;
    wire tmpHit = live && counterValue == tmp_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {buf_reg, tmp_reg, cmp_reg, run_reg, off_reg} <= '0;
        end else begin
            run_reg <= runEnable;
            off_reg <= runEnable && (tmpHit || (!turnHit && off_reg));
            if (dutyWrite) buf_reg <= dutyWriteData;
            if (tick) {tmp_reg, cmp_reg} <= {buf_reg, tmp_reg};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_POS_ON: assert property ($rose(positivePhase) |-> $past(cmpHit))
        else $error("positive on without match");
    AST_POS_OFF: assert property (tmpHit |=> !positivePhase)
        else $error("positive not off");
    AST_OFF_CLEAN: assert property (!positivePhase && tmpHit && !cmpHit
        |=> !positivePhase && negativePhase) else $error("off glitch");
    AST_OFF_FIRST: assert property (cmpHit && off_reg |=> !positivePhase)
        else $error("on not blocked");
    AST_NEG_HOLD: assert property (cmpHit && tmpHit
        |=> $stable(negativePhase)) else $error("negative moved");
    AST_NEG_OFF: assert property (cmpHit && !tmpHit |=> !negativePhase)
        else $error("negative not off");
    AST_NEG_ON: assert property (tmpHit && !cmpHit |=> negativePhase)
        else $error("negative not on");
    AST_TROUGH: assert property (runEnable && !run_reg
        |=> counterUp && counterValue == '0) else $error("no trough start");
endmodule // cpw_channel_monitor
bind cpw_channel cpw_channel_monitor #(.W(W)) u_cpw_channel_monitor (
    .clk(clk), .rst_n(rst_n), .runEnable(runEnable),
    .modeSelect(modeSelect), .carrierPeriodCompare(carrierPeriodCompare),
    .dutyWrite(dutyWrite), .dutyWriteData(dutyWriteData),
    .positivePhase(positivePhase), .negativePhase(negativePhase),
    .counterValue(counterValue), .counterUp(counterUp)
);
`default_nettype wire

// >>> tb/cpw_gate_model.sv
// Purpose: Gate driver pair on the phase outputs
// Assumes: Active high gate commands
// Notes:   Latches shoot-through, which a bridge cannot survive
`default_nettype none
module cpw_gate_model
    import cpw_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic highGate,
    input  wire logic lowGate,
    output var logic  shootThrough
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) shootThrough <= 1'b0;
        else if (highGate && lowGate) shootThrough <= 1'b1;
    end
endmodule // cpw_gate_model
`default_nettype wire

// >>> tb/complementary_pwm_near_zero_duty_bench.sv
// Purpose: Self-checking bench for the PWM channel
// Assumes: Period 20, duty written in either window
// Notes:   Expected phases come from a cycle model beside the design
`default_nettype none
module complementary_pwm_near_zero_duty_bench
    import cpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] P = 16'h0014;
    typedef struct packed {
        logic        mode;
        logic        crest;
        logic [15:0] first;
        logic [15:0] second;
    } cpw_row_t;
    cpw_row_t rows [6] = '{'{1'b0, 1'b1, 16'h000f, P},
        '{1'b0, 1'b0, 16'h000f, P}, '{1'b1, 1'b1, 16'h000f, P},
        '{1'b1, 1'b0, 16'h000f, P}, '{1'b0, 1'b1, 16'h000f, 16'h0016},
        '{1'b1, 1'b0, 16'h000f, 16'h0016}};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        runEnable = 1'b0;
    logic        modeSelect = 1'b0;
    logic        dutyWrite = 1'b0;
    logic [15:0] dutyWriteData = 16'h0000;
    logic [15:0] counterValue;
    logic        positivePhase, negativePhase, counterUp, shootThrough;
    logic        inCountingWindow, inCrestTroughWindow;
    logic        posExp_reg, negExp_reg, offExp_reg;
    int          numErrors = 0;
    int          checked = 0;
    wire cmpHit = u_cpw_channel.u_cpw_channel_monitor.cmpHit;
    wire tmpHit = u_cpw_channel.u_cpw_channel_monitor.tmpHit;
    wire turnHit = u_cpw_channel.u_cpw_channel_monitor.turnHit;
    wire [1:0] phases = {positivePhase, negativePhase};
    wire [1:0] winFlags = {inCrestTroughWindow, inCountingWindow};
    always #5 clk = ~clk;
    cpw_channel #(.W(16), .WIN_CNT(2)) u_cpw_channel (
        .clk(clk), .rst_n(rst_n), .runEnable(runEnable),
        .modeSelect(modeSelect), .carrierPeriodCompare(P),
        .dutyWrite(dutyWrite), .dutyWriteData(dutyWriteData),
        .positivePhase(positivePhase), .negativePhase(negativePhase),
        .counterValue(counterValue), .counterUp(counterUp),
        .inCountingWindow(inCountingWindow),
        .inCrestTroughWindow(inCrestTroughWindow));
    cpw_gate_model u_cpw_gate_model (.clk(clk), .rst_n(rst_n),
        .highGate(positivePhase), .lowGate(negativePhase),
        .shootThrough(shootThrough));
    task automatic fail(input string what);
        numErrors++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic giveVerdict();
        $display("errors %0d, checks %0d", numErrors, checked);
        if (numErrors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] d, input logic crest);
        for (int i = 0; i < 100; i++) begin
            if (counterUp && counterValue == (crest ? P - 16'h1 : 16'ha)) break;
            step(1);
        end
        checked++;
        if (winFlags !== (crest ? 2'b10 : 2'b01)) fail("window");
        dutyWrite = 1'b1;
        dutyWriteData = d;
        step(1);
        dutyWrite = 1'b0;
    endtask
    // off flag spans a half cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || !runEnable) begin
            {posExp_reg, negExp_reg, offExp_reg} <= 3'h0;
        end else begin
            posExp_reg <= !tmpHit && (cmpHit && !offExp_reg || posExp_reg);
            negExp_reg <= cmpHit ? tmpHit && negExp_reg : tmpHit || negExp_reg;
            offExp_reg <= tmpHit || (!turnHit && offExp_reg);
        end
    end
    always @(negedge clk) begin
        if (rst_n) begin
            checked++;
            if (phases !== {posExp_reg, negExp_reg}) fail("phases");
        end
    end
    initial begin
        repeat (6000) @(posedge clk);
        fail("timeout");
        giveVerdict();
    end
    initial begin
        step(16);
        rst_n = 1'b1;
        for (int r = 0; r < 6; r++) begin
            runEnable = 1'b0;
            step(2);
            modeSelect = rows[r].mode;
            runEnable = 1'b1;
            wr(rows[r].first, rows[r].crest);
            step(120);
            wr(rows[r].second, rows[r].crest);
            step(120);
            wr(rows[r].first, rows[r].crest);
            step(120);
        end
        dutyWriteData = 16'h0008;
        dutyWrite = 1'b1;
        step(1);
        dutyWriteData = 16'h000c;
        step(1);
        dutyWrite = 1'b0;
        step(120);
        runEnable = 1'b0;
        rst_n = 1'b0;
        #1;
        checked++;
        if ({phases, counterValue} !== 18'h0) fail("reset");
        step(3);
        rst_n = 1'b1;
        step(2);
        runEnable = 1'b1;
        wr(16'h0005, 1'b0);
        step(120);
        checked++;
        if (shootThrough !== 1'b0) fail("overlap");
        giveVerdict();
    end
endmodule // complementary_pwm_near_zero_duty_bench
`default_nettype wire
